// ---- src/hpr_params.svh ----
/*
 Constants of the home-position-return sequencer: method codes,
 direction and polarity codes, reset values.
 Assumes inclusion by bare name from the design file and the bench.
*/
// Operation
// - Three-bit method field selects one of eight homing methods, codes 0 to 7
// - Direction 0 starts toward increasing address, 1 toward decreasing
// - Polarity 0 detects dog on open input, 1 on shorted input
// - Dog: slow at dog front, home at first marker after rear, plus shift
// - Count: slow at front, travel after-dog distance, first marker, plus shift
// - Data setting: current position becomes home, no dog used
// - Stopper: home where axis stalls against the mechanical stopper
// - Servo-on: position at servo switch-on becomes home
// - Rear-end reference: after dog rear, travel after-dog plus shift, no marker
// - Front-end reference: after dog front, travel after-dog plus shift, no marker
// - Cradle: home at first marker after dog front edge
// - Marker pulse used internally only, never driven out
// - Incremental system: home invalid after every power-on until homed
// - Absolute system: position kept through power-off, no homing needed
// - Started beyond or at dog: back off automatically, then home
`ifndef HPR_PARAMS_SVH
`define HPR_PARAMS_SVH
`define HPR_M_DOG 3'h0
`define HPR_M_COUNT 3'h1
`define HPR_M_DATA 3'h2
`define HPR_M_STOPPER 3'h3
`define HPR_M_SVON 3'h4
`define HPR_M_DOG_REAR 3'h5
`define HPR_M_CNT_FRONT 3'h6
`define HPR_M_CRADLE 3'h7
`define HPR_DIR_INC 1'h0
`define HPR_DOG_POL_SHORT 1'h1
`endif

// ---- src/hpr_pkg.sv ----
/*
 Types of the home-position-return sequencer.
 Assumes hpr_params.svh is on the include path.
*/
package hpr_pkg;
    typedef logic [2:0] hpr_method_t;
    typedef struct packed {
        hpr_method_t method;
        logic dir;
        logic dog_pol;
        logic abs_sys;
    } hpr_cfg_s;
    typedef struct packed {
        logic move_req;
        logic move_dir;
        logic creep;
        logic busy;
        logic home_valid;
        logic done;
    } hpr_stat_s;
    typedef enum logic [3:0] {
        ST_INIT, ST_IDLE, ST_BACKOFF, ST_SEEK, ST_CREEP,
        ST_TRAVEL, ST_WAIT_Z, ST_SHIFT, ST_PRESS
    } hpr_state_e;
endpackage : hpr_pkg

// ---- src/hpr_sequencer.sv ----
/*
 Home-position-return sequencer for one servo axis.
 Assumes dog_in and marker_in are raw pins; all other inputs come
 from logic on clock_in. Steps report encoder motion one count a pulse.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hpr_params.svh"

module hpr_sequencer
    import hpr_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire hpr_cfg_s cfg_in,
    input wire logic start_in,
    input wire logic servo_on_in,
    input wire logic dog_in,
    input wire logic marker_in,
    input wire logic limit_in,
    input wire logic stall_in,
    input wire logic step_in,
    input wire logic step_dec_in,
    input wire logic [POS_W-1:0] after_dog_in,
    input wire logic [POS_W-1:0] shift_in,
    input wire logic [POS_W-1:0] home_data_in,
    input wire logic [POS_W-1:0] abs_pos_in,
    output var hpr_stat_s stat_out,
    output logic [POS_W-1:0] pos_out
);

    localparam logic [POS_W-1:0] POS_ONE = POS_W'(1'h1);

    // Pin synchronisers
    logic dog_s1_reg;
    logic dog_s2_reg;
    logic mark_s1_reg;
    logic mark_s2_reg;
    logic mark_s3_reg;
    logic dog_prev_reg;
    logic svon_prev_reg;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dog_s1_reg <= 1'h0;
            dog_s2_reg <= 1'h0;
            mark_s1_reg <= 1'h0;
            mark_s2_reg <= 1'h0;
            mark_s3_reg <= 1'h0;
        end else begin
            dog_s1_reg <= dog_in;
            dog_s2_reg <= dog_s1_reg;
            mark_s1_reg <= marker_in;
            mark_s2_reg <= mark_s1_reg;
            mark_s3_reg <= mark_s2_reg;
        end
    end

    logic dog_act;
    logic dog_rise;
    logic dog_fall;
    logic z_rise;
    logic svon_rise;

    // Dog polarity
    assign dog_act = (cfg_in.dog_pol == `HPR_DOG_POL_SHORT) ?
        dog_s2_reg : ~dog_s2_reg;
    assign dog_rise = dog_act & ~dog_prev_reg;
    assign dog_fall = ~dog_act & dog_prev_reg;
    // Marker edge, consumed here only
    assign z_rise = mark_s2_reg & ~mark_s3_reg;
    assign svon_rise = servo_on_in & ~svon_prev_reg;

    // Sequencer state
    hpr_state_e state_reg;
    hpr_state_e state_next;
    logic [POS_W-1:0] pos_reg;
    logic [POS_W-1:0] pos_next;
    logic [POS_W-1:0] dist_reg;
    logic [POS_W-1:0] dist_next;
    logic move_reg;
    logic move_next;
    logic mdir_reg;
    logic mdir_next;
    logic creep_reg;
    logic creep_next;
    logic valid_reg;
    logic valid_next;
    logic done_reg;
    logic done_next;
    logic dist_zero;

    assign dist_zero = (dist_reg == '0);

    always_comb begin
        logic finish;
        finish = 1'h0;
        state_next = state_reg;
        pos_next = pos_reg;
        dist_next = dist_reg;
        move_next = move_reg;
        mdir_next = mdir_reg;
        creep_next = creep_reg;
        valid_next = valid_reg;
        done_next = 1'h0;
        if (step_in) begin
            pos_next = step_dec_in ? pos_reg - POS_ONE : pos_reg + POS_ONE;
            if (!dist_zero) begin
                dist_next = dist_reg - POS_ONE;
            end
        end
        unique case (state_reg)
            ST_INIT: begin
                valid_next = cfg_in.abs_sys;
                if (cfg_in.abs_sys) begin
                    pos_next = abs_pos_in;
                end
                state_next = ST_IDLE;
            end
            ST_IDLE: begin
                move_next = 1'h0;
                creep_next = 1'h0;
                if (svon_rise && cfg_in.method == `HPR_M_SVON) begin
                    finish = 1'h1;
                end else if (start_in) begin
                    unique case (cfg_in.method)
                        `HPR_M_DATA: finish = 1'h1;
                        `HPR_M_SVON: finish = 1'h0;
                        `HPR_M_STOPPER: begin
                            valid_next = 1'h0;
                            move_next = 1'h1;
                            mdir_next = cfg_in.dir;
                            state_next = ST_PRESS;
                        end
                        default: begin
                            valid_next = 1'h0;
                            move_next = 1'h1;
                            if (dog_act) begin
                                mdir_next = ~cfg_in.dir;
                                state_next = ST_BACKOFF;
                            end else begin
                                mdir_next = cfg_in.dir;
                                state_next = ST_SEEK;
                            end
                        end
                    endcase
                end
            end
            ST_BACKOFF: begin
                if (dog_fall) begin
                    mdir_next = cfg_in.dir;
                    state_next = ST_SEEK;
                end
            end
            ST_SEEK: begin
                if (limit_in) begin
                    mdir_next = ~cfg_in.dir;
                    state_next = ST_BACKOFF;
                end else if (dog_rise) begin
                    creep_next = 1'h1;
                    unique case (cfg_in.method)
                        `HPR_M_COUNT: begin
                            dist_next = after_dog_in;
                            state_next = ST_TRAVEL;
                        end
                        `HPR_M_CNT_FRONT: begin
                            dist_next = after_dog_in + shift_in;
                            state_next = ST_TRAVEL;
                        end
                        `HPR_M_CRADLE: state_next = ST_WAIT_Z;
                        default: state_next = ST_CREEP;
                    endcase
                end
            end
            ST_CREEP: begin
                if (dog_fall) begin
                    if (cfg_in.method == `HPR_M_DOG_REAR) begin
                        dist_next = after_dog_in + shift_in;
                        state_next = ST_TRAVEL;
                    end else begin
                        state_next = ST_WAIT_Z;
                    end
                end
            end
            ST_TRAVEL: begin
                if (dist_zero) begin
                    if (cfg_in.method == `HPR_M_COUNT) begin
                        state_next = ST_WAIT_Z;
                    end else begin
                        finish = 1'h1;
                    end
                end
            end
            ST_WAIT_Z: begin
                if (z_rise) begin
                    if (cfg_in.method == `HPR_M_CRADLE ||
                            shift_in == '0) begin
                        finish = 1'h1;
                    end else begin
                        dist_next = shift_in;
                        state_next = ST_SHIFT;
                    end
                end
            end
            ST_SHIFT: begin
                if (dist_zero) begin
                    finish = 1'h1;
                end
            end
            ST_PRESS: begin
                if (stall_in) begin
                    finish = 1'h1;
                end
            end
        endcase
        if (finish) begin
            pos_next = home_data_in;
            valid_next = 1'h1;
            done_next = 1'h1;
            move_next = 1'h0;
            creep_next = 1'h0;
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= ST_INIT;
            pos_reg <= '0;
            dist_reg <= '0;
            move_reg <= 1'h0;
            mdir_reg <= `HPR_DIR_INC;
            creep_reg <= 1'h0;
            valid_reg <= 1'h0;
            done_reg <= 1'h0;
            dog_prev_reg <= 1'h0;
            svon_prev_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            pos_reg <= pos_next;
            dist_reg <= dist_next;
            move_reg <= move_next;
            mdir_reg <= mdir_next;
            creep_reg <= creep_next;
            valid_reg <= valid_next;
            done_reg <= done_next;
            dog_prev_reg <= dog_act;
            svon_prev_reg <= servo_on_in;
        end
    end

    assign stat_out.move_req = move_reg;
    assign stat_out.move_dir = mdir_reg;
    assign stat_out.creep = creep_reg;
    assign stat_out.busy = (state_reg != ST_IDLE);
    assign stat_out.home_valid = valid_reg;
    assign stat_out.done = done_reg;
    assign pos_out = pos_reg;

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    logic idle_start;
    assign idle_start = (state_reg == ST_IDLE) && start_in && !svon_rise;

    a_home_load: assert property (
        done_reg |-> pos_reg == $past(home_data_in) && valid_reg)
        else $error("home data not loaded at completion");
    a_data_mode: assert property (
        idle_start && cfg_in.method == `HPR_M_DATA |=> done_reg)
        else $error("data setting did not complete");
    a_svon_home: assert property (
        state_reg == ST_IDLE && svon_rise &&
        cfg_in.method == `HPR_M_SVON |=> done_reg && valid_reg)
        else $error("servo-on position not taken");
    a_start_dir: assert property (
        idle_start && !dog_act && cfg_in.method == `HPR_M_DOG
        |=> move_reg && mdir_reg == $past(cfg_in.dir))
        else $error("wrong start direction");
    a_auto_back: assert property (
        idle_start && dog_act && cfg_in.method == `HPR_M_COUNT
        |=> state_reg == ST_BACKOFF && mdir_reg != $past(cfg_in.dir))
        else $error("no automatic back-off");
    a_limit_rev: assert property (
        state_reg == ST_SEEK && limit_in
        |=> state_reg == ST_BACKOFF && mdir_reg != $past(cfg_in.dir))
        else $error("no reversal at stroke end");
    a_cradle_mark: assert property (
        state_reg == ST_WAIT_Z && z_rise &&
        cfg_in.method == `HPR_M_CRADLE |=> done_reg)
        else $error("cradle home missed marker");
    a_stopper_stall: assert property (
        state_reg == ST_PRESS && stall_in |=> done_reg ##1 !done_reg)
        else $error("stopper stall not taken as home");
    a_front_travel: assert property (
        state_reg == ST_TRAVEL && dist_zero &&
        cfg_in.method == `HPR_M_CNT_FRONT |=> done_reg)
        else $error("front-end travel did not complete");
    a_power_on: assert property (
        state_reg == ST_INIT |=> valid_reg == $past(cfg_in.abs_sys))
        else $error("home validity wrong after power-on");
    a_dog_creep: assert property (
        state_reg == ST_SEEK && !limit_in && dog_rise &&
        cfg_in.method == `HPR_M_DOG |=> creep_reg && state_reg == ST_CREEP)
        else $error("no slow-down at dog front");
    a_count_mark: assert property (
        state_reg == ST_TRAVEL && dist_zero &&
        cfg_in.method == `HPR_M_COUNT |=> state_reg == ST_WAIT_Z)
        else $error("count mode skipped marker wait");

    c_dog_home: cover property (
        state_reg == ST_SHIFT ##[1:1000] done_reg);
    c_backoff: cover property (
        state_reg == ST_BACKOFF ##[1:1000] state_reg == ST_SEEK);
    c_rear_ref: cover property (
        cfg_in.method == `HPR_M_DOG_REAR && done_reg);

endmodule : hpr_sequencer

`default_nettype wire

// ---- dv/hpr_axis_model.sv ----
/*
 Axis model: proximity dog switch, mechanical stopper and encoder.
 Assumes move requests from the sequencer on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module hpr_axis_model #(
    parameter int DOG_LO = 20,
    parameter int DOG_HI = 40,
    parameter int STOP_POS = 60,
    parameter int STEP_GAP = 8
) (
    input wire logic clock_in,
    input wire logic place_in,
    input wire logic [7:0] place_pos_in,
    input wire logic move_req_in,
    input wire logic move_dir_in,
    input wire logic dog_pol_in,
    output logic dog_out,
    output logic marker_out,
    output logic stall_out,
    output logic limit_out,
    output var logic step_out,
    output var logic step_dec_out,
    output var int pos_out
);
    int gap;
    logic on_dog;

    assign on_dog = pos_out >= DOG_LO && pos_out <= DOG_HI;
    // Pin level follows the detection polarity while on the dog
    assign dog_out = on_dog ? dog_pol_in : !dog_pol_in;
    // Marker once every 16 counts, seen only by the sequencer
    assign marker_out = pos_out[3:0] == 4'h0;
    // Stopper blocks further motion toward increasing address
    assign stall_out = pos_out >= STOP_POS;
    // Stroke end switch at count 0, met while moving toward decreasing
    assign limit_out = (pos_out <= 0) && move_dir_in;

    // Slow axis: one count every STEP_GAP cycles while asked to move
    always @(posedge clock_in) begin
        step_out <= 1'b0;
        if (place_in) begin
            pos_out <= int'(place_pos_in);
            gap <= 0;
            step_dec_out <= 1'b0;
        end else if (move_req_in && !(stall_out && !move_dir_in)) begin
            if (gap == STEP_GAP - 1) begin
                gap <= 0;
                step_out <= 1'b1;
                step_dec_out <= move_dir_in;
                pos_out <= move_dir_in ? pos_out - 1 : pos_out + 1;
            end else begin
                gap <= gap + 1;
            end
        end
    end
endmodule : hpr_axis_model

`default_nettype wire

// ---- dv/test_home_position_return_sequencer.sv ----
/*
 Bench: sequencer against the axis model, every homing method.
 Assumes hpr_params.svh is on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hpr_params.svh"

module test_home_position_return_sequencer
    import hpr_pkg::*;
;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic start_in = 1'b0;
    logic servo_on_in = 1'b0;
    logic place = 1'b1;
    logic [7:0] place_pos = 8'h00;
    logic [7:0] lfsr = 8'h48;
    logic [7:0] r;
    hpr_cfg_s cfg = '0;
    logic [31:0] after_dog = '0;
    logic [31:0] shift = '0;
    logic [31:0] home_data = '0;
    logic [31:0] abs_pos = '0;
    hpr_stat_s stat;
    logic [31:0] pos;
    logic dog, marker, stall, limit, step, step_dec;
    int axis_pos;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    hpr_sequencer i_dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .cfg_in(cfg),
        .start_in(start_in), .servo_on_in(servo_on_in), .dog_in(dog),
        .marker_in(marker), .limit_in(limit), .stall_in(stall),
        .step_in(step), .step_dec_in(step_dec), .after_dog_in(after_dog),
        .shift_in(shift), .home_data_in(home_data), .abs_pos_in(abs_pos),
        .stat_out(stat), .pos_out(pos)
    );

    hpr_axis_model i_axis (
        .clock_in(clock_in), .place_in(place), .place_pos_in(place_pos),
        .move_req_in(stat.move_req), .move_dir_in(stat.move_dir),
        .dog_pol_in(cfg.dog_pol), .dog_out(dog), .marker_out(marker),
        .stall_out(stall), .limit_out(limit), .step_out(step),
        .step_dec_out(step_dec),
        .pos_out(axis_pos)
    );

    initial begin
        forever #2 clock_in = ~clock_in;
    end

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction : rnd

    // Axis count where home lands: dog 20..40, marker every 16, limit at 0
    function automatic int expect_home(input logic [2:0] m, input logic d,
                                       input int a, s, p);
        case (m)
            `HPR_M_DOG: return d ? 16 - s : 48 + s;
            `HPR_M_COUNT: return ((20 + a) / 16 + 1) * 16 + s;
            `HPR_M_STOPPER: return 60;
            `HPR_M_DOG_REAR: return 41 + a + s;
            `HPR_M_CNT_FRONT: return 20 + a + s;
            `HPR_M_CRADLE: return 32;
            default: return p;
        endcase
    endfunction : expect_home

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("Checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic run(input logic [2:0] m, input logic d);
        int want;
        int n;
        logic dogm;
        logic crept;
        @(negedge clock_in);
        r = rnd();
        dogm = !(m inside {`HPR_M_DATA, `HPR_M_STOPPER, `HPR_M_SVON});
        crept = 1'b0;
        cfg.method = m;
        cfg.dir = d;
        cfg.dog_pol = r[0];
        cfg.abs_sys = r[1];
        place_pos = (r[2] && !d) ? 8'h1E : 8'h00;
        after_dog = 32'(r[5:3]) + 32'h1;
        shift = 32'(r[7:6]) + 32'(lfsr[0]);
        home_data = {4{rnd()}};
        abs_pos = {4{rnd()}};
        reset_n_in = 1'b0;
        place = 1'b1;
        repeat (2) @(negedge clock_in);
        reset_n_in = 1'b1;
        place = 1'b0;
        @(negedge clock_in);
        check(stat.home_valid, cfg.abs_sys);
        if (cfg.abs_sys) check(pos, abs_pos);
        repeat (2) @(negedge clock_in);
        want = expect_home(m, d, int'(after_dog), int'(shift),
                           int'(place_pos));
        start_in = 1'b1;
        if (m == `HPR_M_SVON) begin
            @(negedge clock_in);
            start_in = 1'b0;
            repeat (3) @(negedge clock_in);
            check(stat.busy, 1'b0);
            servo_on_in = 1'b1;
        end
        @(negedge clock_in);
        start_in = 1'b0;
        if (dogm) begin
            check(stat.move_req, 1'b1);
            check(stat.move_dir, d ^ (place_pos != 8'h00));
            check(stat.home_valid, 1'b0);
            check(stat.busy, 1'b1);
        end
        n = 0;
        while (stat.done !== 1'b1 && n < 2000) begin
            @(negedge clock_in);
            n++;
            if (stat.creep === 1'b1) crept = 1'b1;
        end
        check(32'(n < 2000), 32'h1);
        check(pos, home_data);
        check(stat.home_valid, 1'b1);
        check(axis_pos, want);
        check(32'(crept), 32'(dogm));
        @(negedge clock_in);
        check(stat.done, 1'b0);
        check(stat.move_req, 1'b0);
        check(stat.busy, 1'b0);
        servo_on_in = 1'b0;
    endtask : run

    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        repeat (2) @(negedge clock_in);
        reset_n_in = 1'b1;
        place = 1'b0;
        for (int k = 0; k < 16; k++) begin
            run(3'(k), 1'b0);
        end
        run(`HPR_M_DOG, 1'b1);
        run(`HPR_M_CRADLE, 1'b1);
        reset_n_in = 1'b0;
        @(negedge clock_in);
        end_sim();
    end
endmodule : test_home_position_return_sequencer

`default_nettype wire
